/* File: gvmic_top.sv */
// pin value/monitor registers, interrupt shaping and fault power-down control
// What this block does
// - general output pins drive value bits 7, 6, 5 for pins 1, 2, 3.
// - general input pin levels show in monitor bits 7 to 3.
// - polarity bit 7 low gives active-low interrupt, high gives active-high.
// - event field 0: interrupt held while any unmasked latched flag set.
// - event field 2: 2 ms pulse every 4 ms while unmasked flags remain.
// - event field 3: one 2 ms pulse per unmasked event arriving outside a pulse; value 1 reserved.
// - power-down field 0: faults never power down channels or bias.
// - field 1: unmasked channel faults power down; bias fault per setting.
// - field 2: all channel faults power down; bias as field 1; 3 reserved.
// - readback bit 0 shows all latched flags, 1 only unmasked ones.
// - recovery bit 0: channels power back up when fault disappears.
// - clear-on-read 0: read clears only bits whose live status is zero.
// - clear-on-read 1: read clears all; set again only on new rising live.
// - first mask register resets to all ones.
// - monitor at 0x27, interrupt config at 0x28, page 0, reset zero.
// - output value register at 0x26, page 0, reset zero.
// - function 1 means general output, function 9 means general input.
// - mask bit 0 unmasks a source, 1 masks it.
`timescale 1ns/1ps
`default_nettype none
module gvmic_top #(
  parameter int NCH = 6,
  parameter int CNT_W = 20,
  parameter int PULSE_CYCLES = gvmic_pkg::PULSE_CYCLES_DEF,
  parameter int PERIOD_CYCLES = gvmic_pkg::PERIOD_CYCLES_DEF
) (
  input wire logic CLK,
  input wire logic RST_N,
  input wire gvmic_pkg::gvmic_req_t REG_REQ,
  output logic [7:0] REG_RDATA,
  input wire logic [3:0] PIN1_FUNC,
  input wire logic [3:0] PIN2_FUNC,
  input wire logic [3:0] PIN3_FUNC,
  input wire logic [3:0] INONLY1_FUNC,
  input wire logic [3:0] INONLY2_FUNC,
  input wire logic [4:0] PIN_IN,
  output logic [2:0] PIN_OUT,
  output logic [2:0] PIN_OE,
  input wire logic [7:0] LIVE_STATUS,
  output logic IRQ_PIN,
  input wire logic [NCH-1:0] CH_FAULT,
  input wire logic [NCH-1:0] CH_FAULT_MASKED,
  input wire logic BIAS_FAULT,
  input wire logic BIAS_PD_ALL,
  input wire logic [NCH-1:0] CH_POWERUP_REQ,
  output logic [NCH-1:0] CH_POWERDOWN,
  output logic BIAS_POWERDOWN
);
  import gvmic_pkg::*;

  localparam logic [CNT_W-1:0] PULSE_LAST = CNT_W'(PULSE_CYCLES - 1);
  localparam logic [CNT_W-1:0] PERIOD_LAST = CNT_W'(PERIOD_CYCLES - 1);

  // ---------------------------------------------------------------
  // register access
  // ---------------------------------------------------------------
  function automatic logic hit(input gvmic_req_t r, input logic [7:0] a);
    hit = (r.page == PAGE_MAIN) && (r.addr == a);
  endfunction : hit

  logic [7:0] out_val_reg;
  logic [7:0] mon_reg;
  gvmic_cfg_t cfg_reg;
  logic [7:0] mask_reg;
  logic [7:0] lat_reg;
  logic [7:0] lat_view;
  logic rd_lat;

  assign rd_lat = REG_REQ.rd && hit(REG_REQ, ADDR_LATCHED0);

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      out_val_reg <= RST_PIN_OUT_VAL;
    end else if (REG_REQ.wr && hit(REG_REQ, ADDR_PIN_OUT_VAL)) begin
      out_val_reg <= REG_REQ.wdata & MASK_PIN_OUT_VAL;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      cfg_reg <= RST_IRQ_CFG;
    end else if (REG_REQ.wr && hit(REG_REQ, ADDR_IRQ_CFG)) begin
      cfg_reg <= REG_REQ.wdata;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      mask_reg <= RST_IRQ_MASK0;
    end else if (REG_REQ.wr && hit(REG_REQ, ADDR_IRQ_MASK0)) begin
      mask_reg <= REG_REQ.wdata;
    end
  end

  // unmapped addresses and other pages read as zero
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      REG_RDATA <= 8'h00;
    end else if (REG_REQ.rd) begin
      if (hit(REG_REQ, ADDR_PIN_OUT_VAL)) begin
        REG_RDATA <= out_val_reg;
      end else if (hit(REG_REQ, ADDR_PIN_IN_MON)) begin
        REG_RDATA <= mon_reg;
      end else if (hit(REG_REQ, ADDR_IRQ_CFG)) begin
        REG_RDATA <= cfg_reg;
      end else if (hit(REG_REQ, ADDR_IRQ_MASK0)) begin
        REG_RDATA <= mask_reg;
      end else if (rd_lat) begin
        REG_RDATA <= lat_view;
      end else begin
        REG_RDATA <= 8'h00;
      end
    end
  end

  // ---------------------------------------------------------------
  // pins
  // ---------------------------------------------------------------
  logic [4:0] pin_meta;
  logic [4:0] pin_sync;
  logic [4:0] is_in;
  logic [2:0] is_out;

  assign is_out = {PIN1_FUNC == FUNC_GEN_OUT, PIN2_FUNC == FUNC_GEN_OUT,
                   PIN3_FUNC == FUNC_GEN_OUT};
  assign is_in = {PIN1_FUNC == FUNC_GEN_IN, PIN2_FUNC == FUNC_GEN_IN,
                  PIN3_FUNC == FUNC_GEN_IN, INONLY1_FUNC == FUNC_GEN_IN,
                  INONLY2_FUNC == FUNC_GEN_IN};

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      pin_meta <= 5'h00;
      pin_sync <= 5'h00;
    end else begin
      pin_meta <= PIN_IN;
      pin_sync <= pin_meta;
    end
  end

  // a pin not set up as an input reads zero, not a stale level
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      mon_reg <= 8'h00;
    end else begin
      mon_reg <= {pin_sync & is_in, 3'h0};
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      PIN_OUT <= 3'h0;
      PIN_OE <= 3'h0;
    end else begin
      PIN_OUT <= {out_val_reg[POS_PIN1], out_val_reg[POS_PIN2],
                  out_val_reg[POS_PIN3]};
      PIN_OE <= is_out;
    end
  end

  // ---------------------------------------------------------------
  // latched status
  // ---------------------------------------------------------------
  logic [7:0] live_q;
  logic [7:0] rise;
  logic [7:0] lat_set;
  logic [7:0] lat_clr;

  assign rise = LIVE_STATUS & ~live_q;
  // in keep-while-live mode a live bit keeps its flag; otherwise only an edge sets it
  assign lat_set = cfg_reg.latch_clear_on_read ? rise : LIVE_STATUS;
  assign lat_clr = !rd_lat ? 8'h00 :
                   cfg_reg.latch_clear_on_read ? 8'hff : ~LIVE_STATUS;
  assign lat_view = cfg_reg.latch_readback_select ? (lat_reg & ~mask_reg)
                                                  : lat_reg;

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      live_q <= 8'h00;
    end else begin
      live_q <= LIVE_STATUS;
    end
  end

  // set beats clear so a same-cycle event survives the read
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      lat_reg <= RST_LATCHED0;
    end else begin
      lat_reg <= (lat_reg & ~lat_clr) | lat_set;
    end
  end

  // ---------------------------------------------------------------
  // interrupt shaping
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_PULSE = 2'b10
  } gvmic_pst_t;

  gvmic_pst_t pst_reg;
  logic irq_req;
  logic new_evt;
  logic irq_act;
  logic [CNT_W-1:0] per_cnt_reg;
  logic [CNT_W-1:0] pls_cnt_reg;

  assign irq_req = |(lat_reg & ~mask_reg);
  assign new_evt = |(rise & ~mask_reg);

  // period counter runs only while a request stands, so each burst starts high
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      per_cnt_reg <= '0;
    end else if (!irq_req || cfg_reg.irq_event != EVT_REPEAT) begin
      per_cnt_reg <= '0;
    end else if (per_cnt_reg == PERIOD_LAST) begin
      per_cnt_reg <= '0;
    end else begin
      per_cnt_reg <= per_cnt_reg + 1'b1;
    end
  end

  // events arriving during a pulse merge into it
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      pst_reg <= ST_IDLE;
      pls_cnt_reg <= '0;
    end else if (cfg_reg.irq_event != EVT_SINGLE) begin
      pst_reg <= ST_IDLE;
      pls_cnt_reg <= '0;
    end else begin
      unique case (pst_reg)
        ST_IDLE: begin
          pls_cnt_reg <= '0;
          if (new_evt) begin
            pst_reg <= ST_PULSE;
          end
        end
        ST_PULSE: begin
          if (pls_cnt_reg == PULSE_LAST) begin
            pst_reg <= ST_IDLE;
            pls_cnt_reg <= '0;
          end else begin
            pls_cnt_reg <= pls_cnt_reg + 1'b1;
          end
        end
      endcase
    end
  end

  always_comb begin
    unique case (cfg_reg.irq_event)
      EVT_LEVEL: irq_act = irq_req;
      EVT_REPEAT: irq_act = irq_req && (per_cnt_reg <= PULSE_LAST);
      EVT_SINGLE: irq_act = (pst_reg == ST_PULSE);
      default: irq_act = 1'b0; // reserved code never asserts
    endcase
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      IRQ_PIN <= 1'b1;
    end else begin
      IRQ_PIN <= cfg_reg.irq_polarity ? irq_act : !irq_act;
    end
  end

  // ---------------------------------------------------------------
  // fault power-down
  // ---------------------------------------------------------------
  logic pd_on;
  logic bias_trig;
  logic [NCH-1:0] ch_trig;
  logic [NCH-1:0] ch_fault_any;
  logic [NCH-1:0] ch_recover;

  assign pd_on = (cfg_reg.fault_powerdown_select == PD_UNMASKED) ||
                 (cfg_reg.fault_powerdown_select == PD_ALL);
  assign bias_trig = pd_on && BIAS_FAULT;
  assign ch_fault_any = CH_FAULT | {NCH{BIAS_FAULT && BIAS_PD_ALL}};
  assign ch_trig = !pd_on ? '0 :
                   (cfg_reg.fault_powerdown_select == PD_ALL ? CH_FAULT
                    : (CH_FAULT & ~CH_FAULT_MASKED))
                   | {NCH{bias_trig && BIAS_PD_ALL}};
  // manual mode waits for the host's power-up request after the fault is gone
  assign ch_recover = ~ch_fault_any &
                      (cfg_reg.fault_recovery_select ? CH_POWERUP_REQ
                                                     : {NCH{1'b1}});

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      CH_POWERDOWN <= '0;
    end else begin
      CH_POWERDOWN <= ch_trig | (CH_POWERDOWN & ~ch_recover);
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      BIAS_POWERDOWN <= 1'b0;
    end else begin
      BIAS_POWERDOWN <= bias_trig || (BIAS_POWERDOWN && BIAS_FAULT);
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  logic [2:0] wr_val;
  assign wr_val = REG_REQ.wdata[7:5];

  sequence s_out_write;
    REG_REQ.wr && hit(REG_REQ, ADDR_PIN_OUT_VAL);
  endsequence

  sequence s_single_start;
    cfg_reg.irq_event == EVT_SINGLE && pst_reg == ST_IDLE && new_evt;
  endsequence

  AST_OUT_VAL: assert property (@(posedge CLK) disable iff (!RST_N)
    s_out_write |=> ##1 PIN_OUT == $past(wr_val, 2))
    else $error("pin output does not follow written value");
  AST_MON_ZERO: assert property (@(posedge CLK) disable iff (!RST_N)
    mon_reg[POS_PIN1] |-> $past(PIN1_FUNC) == FUNC_GEN_IN)
    else $error("monitor bit set for a pin that is not an input");
  AST_POLARITY: assert property (@(posedge CLK) disable iff (!RST_N)
    $past(!irq_act) && !$past(cfg_reg.irq_polarity) |-> IRQ_PIN)
    else $error("idle interrupt pin has wrong polarity");
  AST_LEVEL: assert property (@(posedge CLK) disable iff (!RST_N)
    cfg_reg.irq_event == EVT_LEVEL && irq_req |=>
      IRQ_PIN == $past(cfg_reg.irq_polarity))
    else $error("level interrupt not asserted");
  AST_REPEAT: assert property (@(posedge CLK) disable iff (!RST_N)
    cfg_reg.irq_event == EVT_REPEAT && per_cnt_reg > PULSE_LAST |=>
      IRQ_PIN != $past(cfg_reg.irq_polarity))
    else $error("repeat pulse active in its low half");
  AST_SINGLE: assert property (@(posedge CLK) disable iff (!RST_N)
    s_single_start |=> pst_reg == ST_PULSE && pls_cnt_reg == '0)
    else $error("single pulse not started on event");
  AST_PD_OFF: assert property (@(posedge CLK) disable iff (!RST_N)
    !pd_on |=> (CH_POWERDOWN & ~$past(CH_POWERDOWN)) == '0 && !$rose(BIAS_POWERDOWN))
    else $error("power-down raised while disabled");
  AST_PD_UNMASKED: assert property (@(posedge CLK) disable iff (!RST_N)
    cfg_reg.fault_powerdown_select == PD_UNMASKED && CH_FAULT[0] && !CH_FAULT_MASKED[0]
      |=> CH_POWERDOWN[0])
    else $error("unmasked channel fault did not power down");
  AST_AUTO_RECOVER: assert property (@(posedge CLK) disable iff (!RST_N)
    !cfg_reg.fault_recovery_select && !ch_fault_any[0] && !ch_trig[0] |=> !CH_POWERDOWN[0])
    else $error("channel not recovered after fault cleared");
  AST_CLR_LIVE: assert property (@(posedge CLK) disable iff (!RST_N)
    rd_lat && !cfg_reg.latch_clear_on_read |=> (lat_reg & ~$past(LIVE_STATUS)) == 8'h00)
    else $error("flag with clear live status survived read");
  AST_CLR_ALL: assert property (@(posedge CLK) disable iff (!RST_N)
    rd_lat && cfg_reg.latch_clear_on_read |=> lat_reg == $past(rise))
    else $error("read did not clear flags unconditionally");
  AST_MASK_RST: assert property (@(posedge CLK)
    !RST_N |=> mask_reg == RST_IRQ_MASK0)
    else $error("mask register reset value wrong");
endmodule : gvmic_top
`default_nettype wire

/* File: gvmic_pkg.sv */
// shared constants and carrier types for the pin/interrupt configuration block
package gvmic_pkg;
  // ---------------------------------------------------------------
  // register map, page 0x00
  // ---------------------------------------------------------------
  localparam logic [7:0] PAGE_MAIN = 8'h00;
  localparam logic [7:0] ADDR_PIN_OUT_VAL = 8'h26;
  localparam logic [7:0] ADDR_PIN_IN_MON = 8'h27;
  localparam logic [7:0] ADDR_IRQ_CFG = 8'h28;
  localparam logic [7:0] ADDR_IRQ_MASK0 = 8'h29;
  localparam logic [7:0] ADDR_LATCHED0 = 8'h2c;
  localparam logic [7:0] RST_PIN_OUT_VAL = 8'h00;
  localparam logic [7:0] RST_IRQ_CFG = 8'h00;
  localparam logic [7:0] RST_IRQ_MASK0 = 8'hff;
  localparam logic [7:0] RST_LATCHED0 = 8'h00;
  localparam logic [7:0] MASK_PIN_OUT_VAL = 8'he0;
  localparam int POS_PIN1 = 7;
  localparam int POS_PIN2 = 6;
  localparam int POS_PIN3 = 5;
  localparam int POS_INONLY1 = 4;
  localparam int POS_INONLY2 = 3;
  // ---------------------------------------------------------------
  // field encodings
  // ---------------------------------------------------------------
  localparam logic [3:0] FUNC_GEN_OUT = 4'h1;
  localparam logic [3:0] FUNC_GEN_IN = 4'h9;
  localparam logic [1:0] EVT_LEVEL = 2'h0;
  localparam logic [1:0] EVT_REPEAT = 2'h2;
  localparam logic [1:0] EVT_SINGLE = 2'h3;
  localparam logic [1:0] PD_OFF = 2'h0;
  localparam logic [1:0] PD_UNMASKED = 2'h1;
  localparam logic [1:0] PD_ALL = 2'h2;
  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_FREQ_MHZ = 125;
  localparam int PULSE_TIME_US = 2000;
  localparam int PERIOD_TIME_US = 4000;
  localparam int PULSE_CYCLES_DEF = PULSE_TIME_US * CLK_FREQ_MHZ;
  localparam int PERIOD_CYCLES_DEF = PERIOD_TIME_US * CLK_FREQ_MHZ;
  // ---------------------------------------------------------------
  // carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic irq_polarity;
    logic [1:0] irq_event;
    logic [1:0] fault_powerdown_select;
    logic latch_readback_select;
    logic fault_recovery_select;
    logic latch_clear_on_read;
  } gvmic_cfg_t;
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] page;
    logic [7:0] addr;
    logic [7:0] wdata;
  } gvmic_req_t;
endpackage : gvmic_pkg

/* File: gvmic_host_model.sv */
// host-side model: watches the interrupt pin and re-powers channels
`timescale 1ns/1ps
`default_nettype none
module gvmic_host_model #(
  parameter int NCH = 6,
  parameter int PWR_DELAY = 3
) (
  input wire logic clk,
  input wire logic irq_pin,
  input wire logic act_high,
  input wire logic cnt_clr,
  input wire logic pwr_go,
  output logic [15:0] active_cnt,
  output logic [NCH-1:0] powerup_req
);
  int wait_cnt = 0;
  // ----
  // interrupt watch and manual recovery
  // ----
  // active level is the act_high input, which the bench ties low
  always @(posedge clk) begin
    if (cnt_clr) active_cnt <= 16'h0000;
    else if (irq_pin == act_high) active_cnt <= active_cnt + 16'h0001;
  end
  // a slow host: re-powering lands some cycles after it decides to act
  always @(posedge clk) begin
    powerup_req <= {NCH{wait_cnt == 1}};
    if (wait_cnt > 1) wait_cnt <= wait_cnt - 1;
    else if (wait_cnt == 1) wait_cnt <= 0;
    else if (pwr_go) wait_cnt <= PWR_DELAY;
  end
endmodule : gvmic_host_model
`default_nettype wire

/* File: gvmic_top_bench.sv */
// self-checking bench for the pin and interrupt configuration block
`timescale 1ns/1ps
`default_nettype none
module gvmic_top_bench;
  import gvmic_pkg::*;
  localparam int NCH = 6;
  localparam int PULSE = 8;
  localparam int PERIOD = 16;
  localparam int LIMIT = 3000;
  logic CLK = 1'b0;
  logic RST_N = 1'b0;
  gvmic_req_t req = '0;
  logic [7:0] rdata;
  logic [3:0] func = 4'h0;
  logic [4:0] pin_in = 5'h00;
  logic [2:0] pin_out;
  logic [2:0] pin_oe;
  logic [7:0] live = 8'h00;
  logic irq;
  logic [NCH-1:0] fault = '0;
  logic [NCH-1:0] fmask = '0;
  logic [NCH-1:0] pwrdn;
  logic [NCH-1:0] pwr_req;
  logic bias = 1'b0;
  logic bias_all = 1'b0;
  logic bias_pd;
  logic clr = 1'b0;
  logic go = 1'b0;
  logic [15:0] act_cnt;
  int errors = 0;
  int checks_done = 0;
  int cycles = 0;
  logic [7:0] t_addr [5] = '{8'h26, 8'h28, 8'h29, 8'h27, 8'h40};
  logic [7:0] t_wr [5] = '{8'hff, 8'ha5, 8'h5a, 8'hff, 8'h33};
  logic [7:0] t_exp [5] = '{8'he0, 8'ha5, 8'h5a, 8'h00, 8'h00};
  logic [7:0] pd_cfg [3] = '{8'h00, 8'h08, 8'h10};
  logic [7:0] pd_exp [3] = '{8'h00, 8'h01, 8'h03};

  always #4 CLK = ~CLK;

  gvmic_top #(.NCH(NCH), .CNT_W(8), .PULSE_CYCLES(PULSE), .PERIOD_CYCLES(PERIOD)) i_dut (
    .CLK(CLK), .RST_N(RST_N), .REG_REQ(req), .REG_RDATA(rdata),
    .PIN1_FUNC(func), .PIN2_FUNC(func), .PIN3_FUNC(func),
    .INONLY1_FUNC(func), .INONLY2_FUNC(func),
    .PIN_IN(pin_in), .PIN_OUT(pin_out), .PIN_OE(pin_oe),
    .LIVE_STATUS(live), .IRQ_PIN(irq), .CH_FAULT(fault), .CH_FAULT_MASKED(fmask),
    .BIAS_FAULT(bias), .BIAS_PD_ALL(bias_all), .CH_POWERUP_REQ(pwr_req),
    .CH_POWERDOWN(pwrdn), .BIAS_POWERDOWN(bias_pd));
  gvmic_host_model #(.NCH(NCH), .PWR_DELAY(3)) i_host (
    .clk(CLK), .irq_pin(irq), .act_high(1'b0), .cnt_clr(clr), .pwr_go(go),
    .active_cnt(act_cnt), .powerup_req(pwr_req));

  // ----
  // shared tasks
  // ----
  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected %s: expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    req = '{1'b1, 1'b0, PAGE_MAIN, a, d};
    @(negedge CLK);
    req = '0;
    // idle cycle: the next request never lands in the step that clears this one
    @(negedge CLK);
  endtask : wr

  // read data is held until the next read, so it is sampled a full cycle later
  task automatic rc(input string name, input logic [7:0] a, input logic [7:0] exp);
    req = '{1'b0, 1'b1, PAGE_MAIN, a, 8'h00};
    @(negedge CLK);
    req = '0;
    @(negedge CLK);
    chk(name, rdata, exp);
  endtask : rc

  task automatic measure(input int n);
    clr = 1'b1;
    @(negedge CLK);
    clr = 1'b0;
    repeat (n) @(negedge CLK);
  endtask : measure

  task automatic summarize();
    $display("checks %0d mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : summarize

  always @(posedge CLK) begin
    cycles++;
    if (cycles == LIMIT) begin
      errors++;
      $display("timeout after %0d cycles", cycles);
      summarize();
    end
  end

  // ----
  // scenarios
  // ----
  initial begin
    repeat (16) @(negedge CLK);
    chk("irq in reset", {7'h0, irq}, 8'h01);
    RST_N = 1'b1;
    rc("out value", ADDR_PIN_OUT_VAL, 8'h00);
    rc("monitor", ADDR_PIN_IN_MON, 8'h00);
    rc("irq cfg", ADDR_IRQ_CFG, 8'h00);
    rc("mask0", ADDR_IRQ_MASK0, 8'hff);
    $display("test reset done");
    for (int i = 0; i < 5; i++) begin
      wr(t_addr[i], t_wr[i]);
      rc("table read", t_addr[i], t_exp[i]);
    end
    $display("test register table done");
    func = FUNC_GEN_OUT;
    wr(ADDR_PIN_OUT_VAL, 8'ha0);
    repeat (2) @(negedge CLK);
    chk("pin out", {5'h0, pin_out}, 8'h05);
    chk("pin oe", {5'h0, pin_oe}, 8'h07);
    func = FUNC_GEN_IN;
    pin_in = 5'b10110;
    repeat (4) @(negedge CLK);
    chk("pin oe in", {5'h0, pin_oe}, 8'h00);
    rc("monitor in", ADDR_PIN_IN_MON, 8'hb0);
    $display("test pins done");
    wr(ADDR_IRQ_MASK0, 8'h7f);
    wr(ADDR_IRQ_CFG, 8'h00);
    live = 8'hc0;
    @(negedge CLK);
    live = 8'h00;
    repeat (2) @(negedge CLK);
    chk("irq level low", {7'h0, irq}, 8'h00);
    wr(ADDR_IRQ_CFG, 8'h80);
    repeat (2) @(negedge CLK);
    chk("irq level high", {7'h0, irq}, 8'h01);
    rc("latched all", ADDR_LATCHED0, 8'hc0);
    repeat (2) @(negedge CLK);
    chk("irq cleared", {7'h0, irq}, 8'h00);
    wr(ADDR_IRQ_CFG, 8'h04);
    live = 8'h40;
    @(negedge CLK);
    live = 8'h00;
    repeat (2) @(negedge CLK);
    chk("masked no irq", {7'h0, irq}, 8'h01);
    rc("latched unmasked", ADDR_LATCHED0, 8'h00);
    wr(ADDR_IRQ_CFG, 8'h01);
    live = 8'h80;
    repeat (2) @(negedge CLK);
    rc("clear first", ADDR_LATCHED0, 8'h80);
    rc("clear second", ADDR_LATCHED0, 8'h00);
    wr(ADDR_IRQ_CFG, 8'h00);
    rc("live held", ADDR_LATCHED0, 8'h80);
    rc("live held again", ADDR_LATCHED0, 8'h80);
    measure(PERIOD);
    chk("level active", act_cnt[7:0], 8'(PERIOD));
    wr(ADDR_IRQ_CFG, 8'h40);
    repeat (4) @(negedge CLK);
    measure(3 * PERIOD);
    chk("repeat active", act_cnt[7:0], 8'(3 * PULSE));
    wr(ADDR_IRQ_CFG, 8'h20);
    measure(PERIOD);
    chk("reserved event", act_cnt[7:0], 8'h00);
    live = 8'h00;
    wr(ADDR_IRQ_CFG, 8'h60);
    repeat (2) @(negedge CLK);
    live = 8'h80;
    measure(5 * PULSE);
    chk("single pulse", act_cnt[7:0], 8'(PULSE));
    $display("test interrupt done");
    live = 8'h00;
    fault = 6'h03;
    fmask = 6'h02;
    for (int i = 0; i < 3; i++) begin
      wr(ADDR_IRQ_CFG, pd_cfg[i]);
      repeat (2) @(negedge CLK);
      chk("powerdown", {2'h0, pwrdn}, pd_exp[i]);
    end
    bias = 1'b1;
    bias_all = 1'b1;
    repeat (2) @(negedge CLK);
    chk("bias down", {7'h0, bias_pd}, 8'h01);
    chk("bias all", {2'h0, pwrdn}, 8'h3f);
    bias = 1'b0;
    fault = 6'h00;
    repeat (3) @(negedge CLK);
    chk("auto up", {2'h0, pwrdn}, 8'h00);
    chk("bias up", {7'h0, bias_pd}, 8'h00);
    wr(ADDR_IRQ_CFG, 8'h12);
    fault = 6'h01;
    repeat (2) @(negedge CLK);
    fault = 6'h00;
    repeat (4) @(negedge CLK);
    chk("manual hold", {2'h0, pwrdn}, 8'h01);
    go = 1'b1;
    @(negedge CLK);
    go = 1'b0;
    repeat (6) @(negedge CLK);
    chk("manual up", {2'h0, pwrdn}, 8'h00);
    $display("test faults done");
    RST_N = 1'b0;
    repeat (2) @(negedge CLK);
    chk("irq in second reset", {7'h0, irq}, 8'h01);
    RST_N = 1'b1;
    rc("irq cfg after reset", ADDR_IRQ_CFG, 8'h00);
    rc("mask0 after reset", ADDR_IRQ_MASK0, 8'hff);
    rc("out value after reset", ADDR_PIN_OUT_VAL, 8'h00);
    chk("pin out after reset", {5'h0, pin_out}, 8'h00);
    $display("test second reset done");
    summarize();
  end
endmodule : gvmic_top_bench
`default_nettype wire
